// File: rtl/ledsup_pkg.sv
// Shared types and constants of the LED driver state and fault supervisor.
package ledsup_pkg;
   localparam int unsigned CLK_KHZ    = 40000;
   localparam int unsigned T_SS_MS    = 25;
   localparam int unsigned T_BR_MS    = 50;
   localparam int unsigned T_REC_MS   = 100;
   localparam int unsigned T_DIS_MS   = 400;
   localparam int unsigned T_I2C_MS   = 500;
   localparam int unsigned T_SHORT_MS = 5;
   localparam int unsigned SS_CYC     = T_SS_MS * CLK_KHZ;
   localparam int unsigned BR_CYC     = T_BR_MS * CLK_KHZ;
   localparam int unsigned REC_CYC    = T_REC_MS * CLK_KHZ;
   localparam int unsigned DIS_CYC    = T_DIS_MS * CLK_KHZ;
   localparam int unsigned I2C_CYC    = T_I2C_MS * CLK_KHZ;
   localparam int unsigned SHORT_CYC  = T_SHORT_MS * CLK_KHZ;
   localparam int unsigned SS_STEPS   = 256;
   localparam int NCH  = 4;
   localparam int TW   = 25;
   localparam int SW   = 18;
   localparam int DW   = 16;
   localparam int LW   = 8;
   localparam int CW   = 12;
   localparam logic [CW-1:0] CURRENT_SET_PIN_CODE = 12'h3ff;
   localparam int NFLAG      = 7;
   localparam int F_CURRENT_SET_PIN     = 0;
   localparam int F_OTEMP    = 1;
   localparam int F_OPEN     = 2;
   localparam int F_SHORT    = 3;
   localparam int F_GND      = 4;
   localparam int F_INVALID  = 5;
   localparam int F_I2C      = 6;

   typedef enum logic [3:0] {
      ST_INIT      = 4'h0,
      ST_STANDBY   = 4'h1,
      ST_SOFTSTART = 4'h2,
      ST_BOOST_RMP = 4'h3,
      ST_NORMAL    = 4'h4,
      ST_RECOVERY  = 4'h5,
      ST_LATCH     = 4'h6,
      ST_DISCHARGE = 4'h7,
      ST_OFF       = 4'h8
   } ledsup_state_type;

   typedef struct packed {
      logic           en;
      logic           current_set_pin_low;
      logic           overtemp;
      logic           bst_max;
      logic [NCH-1:0] hr_low;
      logic [NCH-1:0] hr_short;
      logic [NCH-1:0] below_hr;
      logic [NCH-1:0] below_gnd;
   } ledsup_anlg_type;

   typedef struct packed {
      logic [NCH-1:0] used;
      logic [1:0]     dim_sel;
      logic [3:0]     bst_freq;
      logic [3:0]     pwm_freq;
   } ledsup_strap_type;

   typedef struct packed {
      ledsup_anlg_type          sync1;
      ledsup_anlg_type          sync2;
      ledsup_state_type         state;
      logic [TW-1:0]            tmr;
      logic [DW-1:0]            ss_div;
      logic [LW-1:0]            ss_lvl;
      logic [NCH-1:0][SW-1:0]   shc;
      logic [TW-1:0]            i2c_cnt;
      logic [NCH-1:0]           dis;
      ledsup_strap_type         strap;
      logic [NFLAG-1:0]         flags;
      logic [CW-1:0]            code;
      logic                     ovr;
      logic                     irq;
      logic                     abort;
   } ledsup_regs_type;
endpackage

// File: rtl/ledsup_top.sv
// State sequencer and LED fault supervisor of a four-channel boost LED driver.
//
// Functional notes
// - Current-set pin low forces code, flags, interrupts.
// - Overtemperature flags, interrupts, standby until it clears.
// - Open string at max boost disables that string.
// - Headroom above short limit over 5ms disables.
// - Soft-start ground short flags and enters recovery.
// - Ramp and normal test idle channels for ground.
// - Unused output not grounded sets invalid flag.
// - Open I2C transaction 500ms flags and aborts.
// - Enable low: all off, discharge 400ms, off.
// - Init: regulator, memory load, strap capture.
// - Configuration writes accepted from standby onward.
// - Standby leaves for soft start when no overtemperature.
// - Soft start lasts 25ms, supply switch ramps.
// - Soft start arms input and ground-short detection.
// - Boost ramp 50ms with reduced current limit.
// - Boost faults armed from boost ramp onward.
// - Normal: strings on only with nonzero brightness.
// - Recovery 100ms off, restart when bright.
// - All strings disabled latches until enable low.
`timescale 1ns/100ps
module ledsup_top
#(
   parameter int unsigned SS_CYC_P    = ledsup_pkg::SS_CYC,
   parameter int unsigned BR_CYC_P    = ledsup_pkg::BR_CYC,
   parameter int unsigned REC_CYC_P   = ledsup_pkg::REC_CYC,
   parameter int unsigned DIS_CYC_P   = ledsup_pkg::DIS_CYC,
   parameter int unsigned I2C_CYC_P   = ledsup_pkg::I2C_CYC,
   parameter int unsigned SHORT_CYC_P = ledsup_pkg::SHORT_CYC
)
(
   input  wire logic                          CLK,
   input  wire logic                          RSTN,
   input  wire ledsup_pkg::ledsup_anlg_type   ANLG,
   input  wire logic                          LDO_READY,
   input  wire logic                          NVM_DONE,
   input  wire logic                          STRAP_DONE,
   input  wire ledsup_pkg::ledsup_strap_type  STRAP_IN,
   input  wire logic                          BRIGHT_NZ,
   input  wire logic                          I2C_OPEN,
   input  wire logic [ledsup_pkg::NFLAG-1:0]  FLAG_CLR,
   output ledsup_pkg::ledsup_state_type       STATE,
   output logic                               LDO_EN,
   output logic                               NVM_LOAD,
   output logic                               STRAP_SAMPLE,
   output ledsup_pkg::ledsup_strap_type       STRAP_OUT,
   output logic                               CFG_WRITE_EN,
   output logic                               SUPPLY_SWITCH_EN,
   output logic [ledsup_pkg::LW-1:0]          SUPPLY_SWITCH_LEVEL,
   output logic                               BOOST_EN,
   output logic                               BOOST_LOW_ILIM,
   output logic                               VIN_FAULT_ARM,
   output logic                               GND_SHORT_ARM,
   output logic                               BOOST_FAULT_ARM,
   output logic [ledsup_pkg::NCH-1:0]         TEST_CURRENT_EN,
   output logic [ledsup_pkg::NCH-1:0]         STRING_EN,
   output logic [ledsup_pkg::NCH-1:0]         BOOST_LOOP_MASK,
   output logic [ledsup_pkg::NCH-1:0]         STRING_DISABLED,
   output logic                               DISCHARGE_EN,
   output logic                               POWER_DOWN,
   output logic                               CURRENT_OVERRIDE,
   output logic [ledsup_pkg::CW-1:0]          STRING_CURRENT_CODE,
   output logic [ledsup_pkg::NFLAG-1:0]       FLAGS,
   output logic                               IRQ_REQ,
   output logic                               I2C_ABORT
);
   import ledsup_pkg::*;

   localparam int unsigned SS_STEP = SS_CYC_P / SS_STEPS;

   ledsup_regs_type   s_ff;
   ledsup_regs_type   nxt_s;
   ledsup_anlg_type   a;
   ledsup_state_type  nst;
   logic [NFLAG-1:0]  set;
   logic [NCH-1:0]    live;
   logic [NCH-1:0]    led_on;
   logic [NCH-1:0]    oth;
   logic [NCH-1:0]    open_hit;
   logic [NCH-1:0]    sh_hit;
   logic [NCH-1:0]    gnd_run;
   logic [NCH-1:0]    gnd_ss;
   logic [NCH-1:0]    inv_ss;
   logic              run;
   logic              act;
   logic              last;

   // Only the second stage of the synchroniser is ever looked at.
   assign a      = s_ff.sync2;
   assign run    = (s_ff.state == ST_BOOST_RMP) || (s_ff.state == ST_NORMAL);
   assign live   = s_ff.strap.used & ~s_ff.dis;
   assign led_on = (s_ff.state == ST_NORMAL) ? (live & {NCH{BRIGHT_NZ}}) : '0;
   assign act    = (s_ff.state != ST_DISCHARGE) && (s_ff.state != ST_OFF);

   always_comb
   begin
      nxt_s       = s_ff;
      nxt_s.sync1 = ANLG;
      nxt_s.sync2 = s_ff.sync1;
      nxt_s.abort = 1'b0;
      set         = '0;
      nst         = s_ff.state;
      open_hit    = '0;
      sh_hit      = '0;
      gnd_run     = '0;
      oth         = '0;
      last        = 1'b0;
      gnd_ss      = s_ff.strap.used & a.below_hr;
      inv_ss      = ~s_ff.strap.used & ~a.below_gnd;

      set[F_CURRENT_SET_PIN] = a.current_set_pin_low;
      nxt_s.ovr   = a.current_set_pin_low;
      nxt_s.code  = a.current_set_pin_low ? CURRENT_SET_PIN_CODE : '0;

      if (!I2C_OPEN)
      begin
         nxt_s.i2c_cnt = '0;
      end
      else if (s_ff.i2c_cnt == TW'(I2C_CYC_P - 1))
      begin
         nxt_s.i2c_cnt = '0;
         nxt_s.abort   = 1'b1;
         set[F_I2C]    = 1'b1;
      end
      else
      begin
         nxt_s.i2c_cnt = s_ff.i2c_cnt + 1'b1;
      end

      for (int i = 0; i < NCH; i++)
      begin
         oth    = live & ~a.hr_short;
         oth[i] = 1'b0;
         open_hit[i] = led_on[i] && a.hr_low[i] && a.bst_max;
         gnd_run[i]  = run && live[i] && !led_on[i] && a.below_gnd[i];
         if (led_on[i] && a.hr_short[i] && (|oth))
         begin
            if (s_ff.shc[i] == SW'(SHORT_CYC_P))
            begin
               sh_hit[i]       = 1'b1;
               nxt_s.shc[i]    = '0;
            end
            else
            begin
               nxt_s.shc[i] = s_ff.shc[i] + 1'b1;
            end
         end
         else
         begin
            nxt_s.shc[i] = '0;
         end
      end

      set[F_OPEN]  = |open_hit;
      set[F_SHORT] = |sh_hit;
      nxt_s.dis    = s_ff.dis | open_hit | sh_hit;

      unique case (s_ff.state)
         ST_INIT:
         begin
            if (LDO_READY && NVM_DONE && STRAP_DONE)
            begin
               nxt_s.strap = STRAP_IN;
               nst         = ST_STANDBY;
            end
         end
         ST_STANDBY:
         begin
            if (!a.overtemp)
            begin
               nst = ST_SOFTSTART;
            end
         end
         ST_SOFTSTART:
         begin
            last = (s_ff.tmr == TW'(SS_CYC_P - 1));
            if (last)
            begin
               set[F_INVALID] = |inv_ss;
               set[F_GND]     = |gnd_ss;
               nst = (|gnd_ss) ? ST_RECOVERY : ST_BOOST_RMP;
            end
         end
         ST_BOOST_RMP:
         begin
            if (|gnd_run)
            begin
               set[F_GND] = 1'b1;
               nst        = ST_RECOVERY;
            end
            else if (s_ff.tmr == TW'(BR_CYC_P - 1))
            begin
               nst = ST_NORMAL;
            end
         end
         ST_NORMAL:
         begin
            if (|gnd_run)
            begin
               set[F_GND] = 1'b1;
               nst        = ST_RECOVERY;
            end
            else if ((s_ff.strap.used != '0) && ((s_ff.strap.used & ~nxt_s.dis) == '0))
            begin
               nst = ST_LATCH;
            end
         end
         ST_RECOVERY:
         begin
            if ((s_ff.tmr >= TW'(REC_CYC_P - 1)) && BRIGHT_NZ)
            begin
               nst = ST_STANDBY;
            end
         end
         ST_LATCH:
         begin
            nst = ST_LATCH;
         end
         ST_DISCHARGE:
         begin
            if (s_ff.tmr == TW'(DIS_CYC_P - 1))
            begin
               nst = ST_OFF;
            end
         end
         ST_OFF:
         begin
            if (a.en)
            begin
               nst       = ST_INIT;
               nxt_s.dis = '0;
            end
         end
         default:
         begin
            nst = ST_INIT;
         end
      endcase

      if (act && (s_ff.state != ST_INIT) && (s_ff.state != ST_LATCH) && a.overtemp)
      begin
         set[F_OTEMP] = 1'b1;
         nst          = ST_STANDBY;
      end
      if (act && !a.en)
      begin
         nst = ST_DISCHARGE;
      end

      nxt_s.state = nst;
      if (nst != s_ff.state)
      begin
         nxt_s.tmr = '0;
      end
      else if (s_ff.tmr != '1)
      begin
         nxt_s.tmr = s_ff.tmr + 1'b1;
      end

      // The supply switch steps up evenly across the soft start.
      if (s_ff.state == ST_SOFTSTART)
      begin
         if (s_ff.ss_div == DW'(SS_STEP - 1))
         begin
            nxt_s.ss_div = '0;
            if (s_ff.ss_lvl != '1)
            begin
               nxt_s.ss_lvl = s_ff.ss_lvl + 1'b1;
            end
         end
         else
         begin
            nxt_s.ss_div = s_ff.ss_div + 1'b1;
         end
      end
      else
      begin
         nxt_s.ss_div = '0;
         nxt_s.ss_lvl = run ? '1 : '0;
      end

      // A new event wins over a clear in the same cycle.
      nxt_s.flags = (s_ff.flags & ~FLAG_CLR) | set;
      nxt_s.irq   = |(set & (~s_ff.flags | FLAG_CLR));
   end

   always_ff @(posedge CLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         // The enable stages start high so that leaving reset is not read as enable low.
         s_ff          <= '0;
         s_ff.sync1.en <= 1'b1;
         s_ff.sync2.en <= 1'b1;
      end
      else
      begin
         s_ff <= nxt_s;
      end
   end

   assign STATE               = s_ff.state;
   assign LDO_EN              = (s_ff.state != ST_OFF);
   assign NVM_LOAD            = (s_ff.state == ST_INIT) && LDO_READY && !NVM_DONE;
   assign STRAP_SAMPLE        = (s_ff.state == ST_INIT) && LDO_READY && NVM_DONE;
   assign STRAP_OUT           = s_ff.strap;
   assign CFG_WRITE_EN        = act && (s_ff.state != ST_INIT);
   assign SUPPLY_SWITCH_EN    = run || (s_ff.state == ST_SOFTSTART);
   assign SUPPLY_SWITCH_LEVEL = s_ff.ss_lvl;
   assign BOOST_EN            = run;
   assign BOOST_LOW_ILIM      = (s_ff.state == ST_BOOST_RMP);
   assign VIN_FAULT_ARM       = SUPPLY_SWITCH_EN;
   assign GND_SHORT_ARM       = SUPPLY_SWITCH_EN;
   assign BOOST_FAULT_ARM     = run;
   assign TEST_CURRENT_EN     = (s_ff.state == ST_SOFTSTART) ? '1 :
                                run ? (live & ~led_on) : '0;
   assign STRING_EN           = led_on;
   assign BOOST_LOOP_MASK     = live;
   assign STRING_DISABLED     = s_ff.dis;
   assign DISCHARGE_EN        = (s_ff.state == ST_DISCHARGE);
   assign POWER_DOWN          = (s_ff.state == ST_OFF);
   assign CURRENT_OVERRIDE    = s_ff.ovr;
   assign STRING_CURRENT_CODE = s_ff.code;
   assign FLAGS               = s_ff.flags;
   assign IRQ_REQ             = s_ff.irq;
   assign I2C_ABORT           = s_ff.abort;

   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!RSTN);

   sequence s_ss_end;
      (s_ff.state == ST_SOFTSTART) && (s_ff.tmr == TW'(SS_CYC_P - 1)) && a.en && !a.overtemp;
   endsequence

   property p_current_set_pin;
      a.current_set_pin_low |=> (STRING_CURRENT_CODE == CURRENT_SET_PIN_CODE) && CURRENT_OVERRIDE && FLAGS[F_CURRENT_SET_PIN];
   endproperty
   a_current_set_pin: assert property (p_current_set_pin) else $error("current-set override missing");

   property p_otemp;
      (s_ff.state == ST_NORMAL) && a.overtemp && a.en
         |=> (STATE == ST_STANDBY) && FLAGS[F_OTEMP]
             && (IRQ_REQ || ($past(FLAGS[F_OTEMP]) && !$past(FLAG_CLR[F_OTEMP])));
   endproperty
   a_otemp: assert property (p_otemp) else $error("overtemperature not handled");

   property p_open;
      (|open_hit) |=> ((STRING_DISABLED & $past(open_hit)) == $past(open_hit)) && FLAGS[F_OPEN];
   endproperty
   a_open: assert property (p_open) else $error("open string not disabled");

   property p_keep;
      (s_ff.state != ST_OFF) |=> ((STRING_DISABLED & $past(s_ff.dis)) == $past(s_ff.dis));
   endproperty
   a_keep: assert property (p_keep) else $error("disabled string came back");

   property p_gnd_ss;
      s_ss_end ##0 (gnd_ss != '0) |=> (STATE == ST_RECOVERY) ##0 FLAGS[F_GND];
   endproperty
   a_gnd_ss: assert property (p_gnd_ss) else $error("ground short missed");

   property p_ss_ok;
      s_ss_end ##0 (gnd_ss == '0)
         |=> (STATE == ST_BOOST_RMP) && BOOST_LOW_ILIM && (SUPPLY_SWITCH_LEVEL == '1);
   endproperty
   a_ss_ok: assert property (p_ss_ok) else $error("soft start did not end");

   property p_i2c;
      I2C_OPEN && (s_ff.i2c_cnt == TW'(I2C_CYC_P - 1)) |=> I2C_ABORT && FLAGS[F_I2C];
   endproperty
   a_i2c: assert property (p_i2c) else $error("serial timeout missed");

   property p_off;
      act && !a.en |=> DISCHARGE_EN && !BOOST_EN && !SUPPLY_SWITCH_EN && (STRING_EN == '0);
   endproperty
   a_off: assert property (p_off) else $error("enable low not obeyed");

   property p_latch;
      (s_ff.state == ST_LATCH) && a.en ##1 a.en |-> (STATE == ST_LATCH)[*2];
   endproperty
   a_latch: assert property (p_latch) else $error("latch fault left");

   property p_rec;
      ($past(s_ff.state) == ST_RECOVERY) && (s_ff.state == ST_STANDBY) && a.en
         |-> ($past(s_ff.tmr) >= TW'(REC_CYC_P - 1)) || $past(a.overtemp);
   endproperty
   a_rec: assert property (p_rec) else $error("recovery left early");

   property p_arm;
      BOOST_FAULT_ARM |-> VIN_FAULT_ARM && GND_SHORT_ARM && CFG_WRITE_EN && BOOST_EN;
   endproperty
   a_arm: assert property (p_arm) else $error("arming out of state");

endmodule

// File: sim/ledsup_far_model.sv
// Regulator, memory loader and strap detector answering the supervisor during start-up.
`timescale 1ns/100ps
module ledsup_far_model
(
   input  wire logic       CLK,
   input  wire logic       RSTN,
   input  wire logic [3:0] DLY,
   input  wire logic       LDO_EN,
   input  wire logic       NVM_LOAD,
   input  wire logic       STRAP_SAMPLE,
   output logic            LDO_READY,
   output logic            NVM_DONE,
   output logic            STRAP_DONE
);
   logic [3:0] cnt_ff;

   // Each step answers DLY+1 cycles after the previous one, so start-up can be prompt or slow.
   always_ff @(posedge CLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         cnt_ff     <= 4'h0;
         LDO_READY  <= 1'b0;
         NVM_DONE   <= 1'b0;
         STRAP_DONE <= 1'b0;
      end
      else if (!LDO_EN)
      begin
         cnt_ff     <= 4'h0;
         LDO_READY  <= 1'b0;
         NVM_DONE   <= 1'b0;
         STRAP_DONE <= 1'b0;
      end
      else if (cnt_ff != DLY)
         cnt_ff <= cnt_ff + 4'h1;
      else
      begin
         cnt_ff <= 4'h0;
         if (!LDO_READY)
            LDO_READY <= 1'b1;
         else if (NVM_LOAD)
            NVM_DONE <= 1'b1;
         else if (STRAP_SAMPLE)
            STRAP_DONE <= 1'b1;
      end
   end
endmodule

// File: sim/ledsup_top_bench.sv
// Self-checking bench of the LED driver state and fault supervisor.
`timescale 1ns/100ps
module ledsup_top_bench;
   import ledsup_pkg::*;
   localparam int SS   = 256;
   localparam int BR   = 40;
   localparam int REC  = 40;
   localparam int DIS  = 40;
   localparam int I2C  = 40;
   localparam int SHT  = 10;
   localparam int WDOG = 4 * (SS + BR + REC) + DIS + I2C + 2000;
   logic             clk = 1'b0;
   logic             rstn = 1'b0;
   ledsup_anlg_type  anlg;
   ledsup_strap_type strap;
   ledsup_strap_type strap_out;
   ledsup_state_type state;
   logic             ldo_rdy, nvm_done, strap_done, bright, i2c_open, ldo_en, nvm_load;
   logic             strap_smp, cfg_we, sw_en, boost_en, low_ilim, vin_arm, gnd_arm, bst_arm;
   logic             dis_en, pdn, ovr, irq, abort;
   logic [3:0]       dly, tcur, str_en, mask, dis;
   logic [7:0]       sw_lvl;
   logic [11:0]      code;
   logic [6:0]       flag_clr, flags;
   int               miscompares = 0;
   int               samples_checked = 0;
   int               irq_cnt = 0;
   int               abort_cnt = 0;
   int               n, k, seed;

   always #12.5 clk = ~clk;

   always @(posedge clk)
   begin
      if (irq === 1'b1)
         irq_cnt++;
      if (abort === 1'b1)
         abort_cnt++;
   end

   ledsup_top #(.SS_CYC_P(SS), .BR_CYC_P(BR), .REC_CYC_P(REC), .DIS_CYC_P(DIS),
                .I2C_CYC_P(I2C), .SHORT_CYC_P(SHT)) i_dut
   (
      .CLK(clk), .RSTN(rstn), .ANLG(anlg), .LDO_READY(ldo_rdy), .NVM_DONE(nvm_done),
      .STRAP_DONE(strap_done), .STRAP_IN(strap), .BRIGHT_NZ(bright), .I2C_OPEN(i2c_open),
      .FLAG_CLR(flag_clr), .STATE(state), .LDO_EN(ldo_en), .NVM_LOAD(nvm_load),
      .STRAP_SAMPLE(strap_smp), .STRAP_OUT(strap_out), .CFG_WRITE_EN(cfg_we),
      .SUPPLY_SWITCH_EN(sw_en), .SUPPLY_SWITCH_LEVEL(sw_lvl), .BOOST_EN(boost_en),
      .BOOST_LOW_ILIM(low_ilim), .VIN_FAULT_ARM(vin_arm), .GND_SHORT_ARM(gnd_arm),
      .BOOST_FAULT_ARM(bst_arm), .TEST_CURRENT_EN(tcur), .STRING_EN(str_en),
      .BOOST_LOOP_MASK(mask), .STRING_DISABLED(dis), .DISCHARGE_EN(dis_en),
      .POWER_DOWN(pdn), .CURRENT_OVERRIDE(ovr), .STRING_CURRENT_CODE(code),
      .FLAGS(flags), .IRQ_REQ(irq), .I2C_ABORT(abort)
   );

   ledsup_far_model i_far
   (
      .CLK(clk), .RSTN(rstn), .DLY(dly), .LDO_EN(ldo_en), .NVM_LOAD(nvm_load),
      .STRAP_SAMPLE(strap_smp), .LDO_READY(ldo_rdy), .NVM_DONE(nvm_done),
      .STRAP_DONE(strap_done)
   );

   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic settle(input int c);
      repeat (c) @(negedge clk);
   endtask

   // Counts falling edges until the state is reached; a wait past the limit is a mismatch.
   task automatic wait_state(input ledsup_state_type s, input int lim, output int c);
      c = 0;
      while (state !== s && c < lim)
      begin
         @(negedge clk);
         c++;
      end
      if (state !== s)
      begin
         miscompares++;
         $display("Error at %0t: state %h never reached", $time, s);
      end
   endtask

   task automatic finish_test;
      $display("Compared %0d samples, %0d miscompares", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   initial
   begin
      repeat (WDOG) @(posedge clk);
      miscompares++;
      finish_test;
   end

   initial
   begin
      seed = $urandom(11);
      anlg = '0;
      anlg.en = 1'b1;
      strap = '0;
      strap.used = 4'hf;
      strap.dim_sel = 2'($urandom);
      strap.bst_freq = 4'($urandom);
      strap.pwm_freq = 4'($urandom);
      dly = 4'($urandom);
      bright = 1'b1;
      i2c_open = 1'b0;
      flag_clr = 7'h00;
      repeat (12) @(posedge clk);
      rstn <= 1'b1;
      wait_state(ST_STANDBY, 300, n);
      check(strap_out, strap);
      check(cfg_we, 1'b1);
      wait_state(ST_SOFTSTART, 4, n);
      check(n, 1);
      check({sw_en, vin_arm, gnd_arm, boost_en, tcur}, 8'hef);
      wait_state(ST_BOOST_RMP, SS + 4, n);
      check(n, SS);
      check({sw_lvl, boost_en, low_ilim, bst_arm}, 11'h7ff);
      wait_state(ST_NORMAL, BR + 4, n);
      check(n, BR);
      for (int i = 0; i < 8; i++)
      begin
         @(posedge clk);
         bright <= 1'($urandom);
         @(negedge clk);
         check(str_en, bright ? 4'hf : 4'h0);
      end
      @(posedge clk);
      bright <= 1'b1;
      anlg.current_set_pin_low <= 1'b1;
      k = irq_cnt;
      settle(5);
      check({ovr, code, flags[F_CURRENT_SET_PIN], state}, {1'b1, CURRENT_SET_PIN_CODE, 1'b1, ST_NORMAL});
      check(irq_cnt > k, 1'b1);
      @(posedge clk);
      anlg.current_set_pin_low <= 1'b0;
      settle(4);
      @(posedge clk);
      flag_clr <= 7'h01;
      @(posedge clk);
      flag_clr <= 7'h00;
      settle(2);
      check({ovr, code, flags[F_CURRENT_SET_PIN]}, 14'h0);
      @(posedge clk);
      i2c_open <= 1'b1;
      settle(I2C + 6);
      @(posedge clk);
      i2c_open <= 1'b0;
      settle(1);
      check({abort_cnt, flags[F_I2C], state}, {32'd1, 1'b1, ST_NORMAL});
      @(posedge clk);
      anlg.hr_low <= 4'h1;
      anlg.bst_max <= 1'b1;
      settle(5);
      check({dis, mask, str_en[0], flags[F_OPEN]}, 10'h079);
      @(posedge clk);
      anlg.hr_low <= 4'h0;
      anlg.bst_max <= 1'b0;
      anlg.hr_short <= 4'h2;
      settle(SHT - 2);
      check(dis[1], 1'b0);
      settle(8);
      check({dis, flags[F_SHORT]}, 5'h07);
      @(posedge clk);
      anlg.hr_short <= 4'h0;
      bright <= 1'b0;
      anlg.below_gnd <= 4'h4;
      wait_state(ST_RECOVERY, 6, n);
      check({flags[F_GND], sw_en, boost_en, str_en}, 7'h40);
      @(posedge clk);
      anlg.below_gnd <= 4'h0;
      settle(REC + 5);
      check(state, ST_RECOVERY);
      @(posedge clk);
      bright <= 1'b1;
      flag_clr <= 7'h10;
      @(posedge clk);
      flag_clr <= 7'h00;
      anlg.below_hr <= 4'h8;
      wait_state(ST_SOFTSTART, 8, n);
      wait_state(ST_RECOVERY, SS + 4, n);
      check({n, flags[F_GND]}, {SS, 1'b1});
      @(posedge clk);
      anlg.below_hr <= 4'h0;
      wait_state(ST_STANDBY, REC + 8, n);
      check(n >= REC - 1, 1'b1);
      wait_state(ST_NORMAL, SS + BR + 8, n);
      check(dis, 4'h3);
      @(posedge clk);
      anlg.overtemp <= 1'b1;
      wait_state(ST_STANDBY, 6, n);
      settle(10);
      check({state, flags[F_OTEMP], boost_en}, {ST_STANDBY, 2'b10});
      @(posedge clk);
      anlg.overtemp <= 1'b0;
      wait_state(ST_NORMAL, SS + BR + 10, n);
      @(posedge clk);
      anlg.hr_low <= 4'hc;
      anlg.bst_max <= 1'b1;
      wait_state(ST_LATCH, 8, n);
      check(dis, 4'hf);
      @(posedge clk);
      anlg.hr_low <= 4'h0;
      anlg.bst_max <= 1'b0;
      settle(20);
      check(state, ST_LATCH);
      @(posedge clk);
      anlg.en <= 1'b0;
      wait_state(ST_DISCHARGE, 6, n);
      check({dis_en, boost_en, sw_en, str_en}, 7'h40);
      wait_state(ST_OFF, DIS + 4, n);
      check({n, pdn, ldo_en}, {DIS, 2'b10});
      // Restart with output 3 configured unused but not grounded.
      @(posedge clk);
      anlg.en <= 1'b1;
      strap.used <= 4'h7;
      wait_state(ST_STANDBY, 300, n);
      check(dis, 4'h0);
      check(strap_out.used, 4'h7);
      k = irq_cnt;
      wait_state(ST_BOOST_RMP, SS + 8, n);
      check({flags[F_INVALID], tcur, mask}, {1'b1, 4'h7, 4'h7});
      settle(2);
      check(irq_cnt > k, 1'b1);
      finish_test;
   end
endmodule
